//--- rtl/cpwm_defs.vh
`ifndef CPWM_DEFS_VH
`define CPWM_DEFS_VH

// Register byte offsets on the AHB-Lite bus, one aligned word each.
`define CPWM_OFS_CTRL4      8'h00
`define CPWM_OFS_CNT3       8'h04
`define CPWM_OFS_CNT4       8'h08
`define CPWM_OFS_PER3       8'h0C
`define CPWM_OFS_DUTY3      8'h10
`define CPWM_OFS_PERBUF3    8'h14
`define CPWM_OFS_DUTYBUF3   8'h18
`define CPWM_OFS_DUTYA4     8'h1C
`define CPWM_OFS_DUTYB4     8'h20
`define CPWM_OFS_DUTYBUFA4  8'h24
`define CPWM_OFS_DUTYBUFB4  8'h28
`define CPWM_OFS_DEAD       8'h2C
`define CPWM_OFS_HALF       8'h30
`define CPWM_OFS_HALFBUF    8'h34
`define CPWM_OFS_OUTCTL     8'h38
`define CPWM_OFS_MODE3      8'h3C
`define CPWM_OFS_RUN        8'h40

// Field positions.
`define CPWM_CLR_HI         7
`define CPWM_CLR_LO         5
`define CPWM_EDGE_HI        4
`define CPWM_EDGE_LO        3
`define CPWM_PSC_HI         2
`define CPWM_PSC_LO         0
`define CPWM_SYNC_BIT       6
`define CPWM_LOCK_BIT       3
`define CPWM_SRC_BIT        2
`define CPWM_NLVL_BIT       1
`define CPWM_PLVL_BIT       0
`define CPWM_BUFE_BIT       6
`define CPWM_BUFB_BIT       5
`define CPWM_BUFA_BIT       4
`define CPWM_MD_HI          3
`define CPWM_MD_LO          0
`define CPWM_RUN_BIT        0

// Field codes.
`define CPWM_MODE_COMP3     4'hF
`define CPWM_CLR_NONE       3'h0
`define CPWM_EDGE_RISE      2'h0
`define CPWM_EDGE_FALL      2'h1
`define CPWM_PSC_DIV1       3'h0
`define CPWM_PSC_DIV4       3'h1
`define CPWM_PSC_DIV16      3'h2
`define CPWM_PSC_DIV64      3'h3

// Last count of the prescaler for each division ratio.
`define CPWM_DIV1_LAST      6'h00
`define CPWM_DIV4_LAST      6'h03
`define CPWM_DIV16_LAST     6'h0F
`define CPWM_DIV64_LAST     6'h3F

// Reset values.
`define CPWM_RST_BYTE       8'h00
`define CPWM_RST_WORD       16'h0000
`define CPWM_RST_RDATA      32'h00000000

`endif

//--- rtl/cpwm_prescaler.v
`timescale 1ns/10ps
`include "cpwm_defs.vh"

module cpwm_prescaler (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       run,
    input  wire [2:0] prescaleSel,
    input  wire [1:0] edgeSel,
    output reg        countTick
);

    reg  [5:0] divCount;
    reg  [5:0] divLast;
    wire       riseEdge;
    wire       fallEdge;

    // Division ratio of the internal counting clock.
    always @* begin
        case (prescaleSel)
            `CPWM_PSC_DIV1:  divLast = `CPWM_DIV1_LAST;
            `CPWM_PSC_DIV4:  divLast = `CPWM_DIV4_LAST;
            `CPWM_PSC_DIV16: divLast = `CPWM_DIV16_LAST;
            `CPWM_PSC_DIV64: divLast = `CPWM_DIV64_LAST;
            default:         divLast = `CPWM_DIV1_LAST;
        endcase
    end

    // The divided clock rises at the wrap and falls half way through.
    assign riseEdge = (divCount == divLast);
    assign fallEdge = (divLast == `CPWM_DIV1_LAST) ? 1'b1 : (divCount == (divLast >> 1));

    // Free running divider, held at zero while stopped.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            divCount  <= 6'h00;
            countTick <= 1'b0;
        end else if (!run) begin
            divCount  <= 6'h00;
            countTick <= 1'b0;
        end else begin
            divCount <= riseEdge ? 6'h00 : divCount + 6'h01;
            case (edgeSel)
                `CPWM_EDGE_RISE: countTick <= riseEdge;
                `CPWM_EDGE_FALL: countTick <= fallEdge;
                default:         countTick <= riseEdge | fallEdge;
            endcase
        end
    end

endmodule

//--- rtl/cpwm_phase.v
`timescale 1ns/10ps

module cpwm_phase (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        run,
    input  wire        countTick,
    input  wire        demand,
    input  wire [15:0] deadTime,
    input  wire        posLevel,
    input  wire        negLevel,
    output reg         posPin,
    output reg         negPin
);

    reg        lastDemand;
    reg [15:0] gapCount;
    reg        inGap;

    // A change of demand first turns both sides off for the dead time.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lastDemand <= 1'b0;
            gapCount   <= 16'h0000;
            inGap      <= 1'b0;
            posPin     <= 1'b0;
            negPin     <= 1'b0;
        end else if (!run) begin
            lastDemand <= 1'b0;
            gapCount   <= 16'h0000;
            inGap      <= 1'b0;
            posPin     <= ~posLevel;
            negPin     <= ~negLevel;
        end else if (demand != lastDemand) begin
            lastDemand <= demand;
            gapCount   <= deadTime;
            inGap      <= 1'b1;
            posPin     <= ~posLevel;
            negPin     <= ~negLevel;
        end else if (inGap) begin
            if (gapCount == 16'h0000) begin
                inGap <= 1'b0;
            end else if (countTick) begin
                gapCount <= gapCount - 16'h0001;
            end
            posPin <= ~posLevel;
            negPin <= ~negLevel;
        end else begin
            // Exactly one side active outside the gap.
            posPin <= lastDemand ? posLevel : ~posLevel;
            negPin <= lastDemand ? ~negLevel : negLevel;
        end
    end

endmodule

//--- rtl/cpwm_timer.v
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "cpwm_defs.vh"

module cpwm_timer (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    output reg         ch3PinA,
    output reg         phaseUPositivePin,
    output reg         phaseUNegativePin,
    output reg         phaseVPositivePin,
    output reg         phaseVNegativePin,
    output reg         phaseWPositivePin,
    output reg         phaseWNegativePin
);

    // Software visible registers.
    reg  [7:0]  ch4CounterControl;
    reg  [15:0] ch3CountValue;
    reg  [15:0] ch4CountValue;
    reg  [15:0] ch3PeriodCompare;
    reg  [15:0] ch3DutyCompare;
    reg  [15:0] ch3PeriodBuffer;
    reg  [15:0] ch3DutyBuffer;
    reg  [15:0] ch4DutyCompareA;
    reg  [15:0] ch4DutyCompareB;
    reg  [15:0] ch4DutyBufferA;
    reg  [15:0] ch4DutyBufferB;
    reg  [15:0] deadTimeValue;
    reg  [15:0] halfPeriodValue;
    reg  [15:0] halfPeriodBuffer;
    reg  [7:0]  outputControlOne;
    reg  [7:0]  ch3ModeSelect;
    reg         runEnable;

    // Bus and counter state.
    reg         writePending;
    reg  [7:0]  writeAddr;
    reg         readPending;
    reg  [7:0]  readAddr;
    reg         ch3CountDown;
    reg         ch4CountDown;
    reg  [31:0] next_hrdata;
    wire        accessValid;
    wire        wordSize;
    wire        wrEn;
    wire        countTick;
    wire        compMode;
    wire        timerRun;
    wire        periodEdge;
    wire        bufOpA;
    wire        bufOpB;
    wire        writeLock;
    wire        useLevels;
    wire        posLevel;
    wire        negLevel;
    wire [15:0] wData;
    wire [2:0]  phaseDemand;
    wire [5:0]  phaseDrive;
    wire [47:0] phaseDuty;

    assign accessValid = hsel & hready & htrans[1];
    assign wordSize    = (hsize == 3'h2);
    assign wrEn        = writePending;
    assign wData       = hwdata[15:0];

    // Mode and control decode.
    assign compMode   = (ch3ModeSelect[`CPWM_MD_HI:`CPWM_MD_LO] == `CPWM_MODE_COMP3);
    assign timerRun   = runEnable & compMode;
    assign bufOpA     = ch3ModeSelect[`CPWM_BUFA_BIT];
    assign bufOpB     = ch3ModeSelect[`CPWM_BUFB_BIT];
    assign writeLock  = outputControlOne[`CPWM_LOCK_BIT];
    assign useLevels  = ~outputControlOne[`CPWM_SRC_BIT];
    assign posLevel   = useLevels ? outputControlOne[`CPWM_PLVL_BIT] : 1'b1;
    assign negLevel   = useLevels ? outputControlOne[`CPWM_NLVL_BIT] : 1'b1;

    // The carrier period ends when channel 4 reaches zero counting down.
    assign periodEdge = timerRun & countTick & ch4CountDown
                        & (ch4CountValue == `CPWM_RST_WORD);

    // Shared prescaler and edge selection for both counters.
    cpwm_prescaler prescaler (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .run         (timerRun),
        .prescaleSel (ch4CounterControl[`CPWM_PSC_HI:`CPWM_PSC_LO]),
        .edgeSel     (ch4CounterControl[`CPWM_EDGE_HI:`CPWM_EDGE_LO]),
        .countTick   (countTick)
    );

    // Phase W, V and U duty sources in that order, from the top bits down.
    assign phaseDuty = {ch4DutyCompareB, ch4DutyCompareA, ch3DutyCompare};

    // One dead-time pair generator per phase.
    genvar ph;
    generate
        for (ph = 0; ph < 3; ph = ph + 1) begin : gPhase
            assign phaseDemand[ph] = (ch4CountValue >= phaseDuty[ph*16 +: 16]);
            cpwm_phase pair (
                .clk_sys   (clk_sys),
                .rst_n     (rst_n),
                .run       (timerRun),
                .countTick (countTick),
                .demand    (phaseDemand[ph]),
                .deadTime  (deadTimeValue),
                .posLevel  (posLevel),
                .negLevel  (negLevel),
                .posPin    (phaseDrive[2*ph]),
                .negPin    (phaseDrive[2*ph+1])
            );
        end
    endgenerate

    // Pins leave the block through one more flop stage.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phaseUPositivePin <= 1'b0;
            phaseUNegativePin <= 1'b0;
            phaseVPositivePin <= 1'b0;
            phaseVNegativePin <= 1'b0;
            phaseWPositivePin <= 1'b0;
            phaseWNegativePin <= 1'b0;
        end else begin
            phaseUPositivePin <= phaseDrive[0];
            phaseUNegativePin <= phaseDrive[1];
            phaseVPositivePin <= phaseDrive[2];
            phaseVNegativePin <= phaseDrive[3];
            phaseWPositivePin <= phaseDrive[4];
            phaseWNegativePin <= phaseDrive[5];
        end
    end

    // AHB-Lite address phase capture; reads take one wait state.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            writePending <= 1'b0;
            writeAddr    <= `CPWM_RST_BYTE;
            readPending  <= 1'b0;
            readAddr     <= `CPWM_RST_BYTE;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
            hrdata       <= `CPWM_RST_RDATA;
        end else begin
            writePending <= accessValid & hwrite & wordSize;
            writeAddr    <= haddr[7:0];
            hresp        <= 1'b0;
            if (readPending) begin
                readPending <= 1'b0;
                hreadyout   <= 1'b1;
                hrdata      <= next_hrdata;
            end else if (accessValid & ~hwrite) begin
                readPending <= 1'b1;
                readAddr    <= haddr[7:0];
                hreadyout   <= 1'b0;
            end
        end
    end

    // Read multiplexer; unmapped words read as zero.
    always @* begin
        next_hrdata = `CPWM_RST_RDATA;
        case (readAddr)
            `CPWM_OFS_CTRL4:     next_hrdata[7:0]  = ch4CounterControl;
            `CPWM_OFS_CNT3:      next_hrdata[15:0] = ch3CountValue;
            `CPWM_OFS_CNT4:      next_hrdata[15:0] = ch4CountValue;
            `CPWM_OFS_PER3:      next_hrdata[15:0] = ch3PeriodCompare;
            `CPWM_OFS_DUTY3:     next_hrdata[15:0] = ch3DutyCompare;
            `CPWM_OFS_PERBUF3:   next_hrdata[15:0] = ch3PeriodBuffer;
            `CPWM_OFS_DUTYBUF3:  next_hrdata[15:0] = ch3DutyBuffer;
            `CPWM_OFS_DUTYA4:    next_hrdata[15:0] = ch4DutyCompareA;
            `CPWM_OFS_DUTYB4:    next_hrdata[15:0] = ch4DutyCompareB;
            `CPWM_OFS_DUTYBUFA4: next_hrdata[15:0] = ch4DutyBufferA;
            `CPWM_OFS_DUTYBUFB4: next_hrdata[15:0] = ch4DutyBufferB;
            `CPWM_OFS_DEAD:      next_hrdata[15:0] = deadTimeValue;
            `CPWM_OFS_HALF:      next_hrdata[15:0] = halfPeriodValue;
            `CPWM_OFS_HALFBUF:   next_hrdata[15:0] = halfPeriodBuffer;
            `CPWM_OFS_OUTCTL:    next_hrdata[7:0]  = outputControlOne;
            `CPWM_OFS_MODE3:     next_hrdata[7:0]  = ch3ModeSelect;
            `CPWM_OFS_RUN:       next_hrdata[0]    = runEnable;
            default:             next_hrdata       = `CPWM_RST_RDATA;
        endcase
    end

    // Configuration registers that software alone changes.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ch4CounterControl <= `CPWM_RST_BYTE;
            ch3PeriodBuffer   <= `CPWM_RST_WORD;
            ch3DutyBuffer     <= `CPWM_RST_WORD;
            ch4DutyBufferA    <= `CPWM_RST_WORD;
            ch4DutyBufferB    <= `CPWM_RST_WORD;
            deadTimeValue     <= `CPWM_RST_WORD;
            halfPeriodBuffer  <= `CPWM_RST_WORD;
            outputControlOne  <= `CPWM_RST_BYTE;
            ch3ModeSelect     <= `CPWM_RST_BYTE;
            runEnable         <= 1'b0;
        end else if (wrEn) begin
            case (writeAddr)
                // Only code 000 is defined, so no event ever clears a counter.
                `CPWM_OFS_CTRL4:     ch4CounterControl <= hwdata[7:0];
                `CPWM_OFS_PERBUF3:   ch3PeriodBuffer   <= wData;
                `CPWM_OFS_DUTYBUF3:  ch3DutyBuffer     <= wData;
                `CPWM_OFS_DUTYBUFA4: ch4DutyBufferA    <= wData;
                `CPWM_OFS_DUTYBUFB4: ch4DutyBufferB    <= wData;
                `CPWM_OFS_DEAD:      deadTimeValue     <= wData;
                `CPWM_OFS_HALFBUF:   halfPeriodBuffer  <= wData;
                `CPWM_OFS_OUTCTL: begin
                    outputControlOne[`CPWM_SYNC_BIT] <= hwdata[`CPWM_SYNC_BIT];
                    // The lock bit is sticky until reset.
                    outputControlOne[`CPWM_LOCK_BIT] <= writeLock | hwdata[`CPWM_LOCK_BIT];
                    if (!writeLock) begin
                        outputControlOne[2:0] <= hwdata[2:0];
                    end
                end
                // Bit 6 is reserved and always stays zero.
                `CPWM_OFS_MODE3:     ch3ModeSelect     <= {2'h0, hwdata[5:0]};
                `CPWM_OFS_RUN:       runEnable         <= hwdata[`CPWM_RUN_BIT];
                default:             runEnable         <= runEnable;
            endcase
        end
    end

    // Active compares: direct writes, else buffer loads at the period edge.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ch3PeriodCompare <= `CPWM_RST_WORD;
            ch3DutyCompare   <= `CPWM_RST_WORD;
            ch4DutyCompareA  <= `CPWM_RST_WORD;
            ch4DutyCompareB  <= `CPWM_RST_WORD;
            halfPeriodValue  <= `CPWM_RST_WORD;
        end else begin
            if (periodEdge) begin
                halfPeriodValue <= halfPeriodBuffer;
                if (bufOpA) begin
                    ch3PeriodCompare <= ch3PeriodBuffer;
                    ch4DutyCompareA  <= ch4DutyBufferA;
                end
                if (bufOpB) begin
                    ch3DutyCompare  <= ch3DutyBuffer;
                    ch4DutyCompareB <= ch4DutyBufferB;
                end
            end
            if (wrEn) begin
                case (writeAddr)
                    `CPWM_OFS_PER3:   ch3PeriodCompare <= wData;
                    `CPWM_OFS_DUTY3:  ch3DutyCompare   <= wData;
                    `CPWM_OFS_DUTYA4: ch4DutyCompareA  <= wData;
                    `CPWM_OFS_DUTYB4: ch4DutyCompareB  <= wData;
                    `CPWM_OFS_HALF:   halfPeriodValue  <= wData;
                    // Other writes must not undo a buffer load in this cycle.
                    default: ;
                endcase
            end
        end
    end

    // Channel 3 runs between dead time and its period compare.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ch3CountValue <= `CPWM_RST_WORD;
            ch3CountDown  <= 1'b0;
        end else if (wrEn && writeAddr == `CPWM_OFS_CNT3) begin
            ch3CountValue <= wData;
            ch3CountDown  <= 1'b0;
        end else if (!runEnable) begin
            ch3CountDown <= 1'b0;
        end else if (timerRun && countTick) begin
            if (!ch3CountDown) begin
                if (ch3CountValue == ch3PeriodCompare) begin
                    ch3CountDown  <= 1'b1;
                    ch3CountValue <= ch3CountValue - 16'h0001;
                end else begin
                    ch3CountValue <= ch3CountValue + 16'h0001;
                end
            end else if (ch3CountValue == deadTimeValue) begin
                ch3CountDown  <= 1'b0;
                ch3CountValue <= ch3CountValue + 16'h0001;
            end else begin
                ch3CountValue <= ch3CountValue - 16'h0001;
            end
        end
    end

    // Channel 4 runs between zero and the half period.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ch4CountValue <= `CPWM_RST_WORD;
            ch4CountDown  <= 1'b0;
        end else if (wrEn && writeAddr == `CPWM_OFS_CNT4) begin
            ch4CountValue <= wData;
            ch4CountDown  <= 1'b0;
        end else if (!runEnable) begin
            ch4CountDown <= 1'b0;
        end else if (timerRun && countTick) begin
            if (!ch4CountDown) begin
                if (ch4CountValue == halfPeriodValue) begin
                    ch4CountDown  <= 1'b1;
                    ch4CountValue <= ch4CountValue - 16'h0001;
                end else begin
                    ch4CountValue <= ch4CountValue + 16'h0001;
                end
            end else if (ch4CountValue == `CPWM_RST_WORD) begin
                ch4CountDown  <= 1'b0;
                ch4CountValue <= ch4CountValue + 16'h0001;
            end else begin
                ch4CountValue <= ch4CountValue - 16'h0001;
            end
        end
    end

    // Toggle pin flips once per carrier period when enabled.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ch3PinA <= 1'b0;
        end else if (periodEdge && outputControlOne[`CPWM_SYNC_BIT]) begin
            ch3PinA <= ~ch3PinA;
        end
    end

endmodule

//--- testbench/cpwm_timer_asserts.sv
`timescale 1ns/10ps
module cpwm_timer_asserts (
    input wire        clk_sys,
    input wire        rst_n,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    input wire        ch3PinA,
    input wire        phaseUPositivePin,
    input wire        phaseUNegativePin,
    input wire        phaseVPositivePin,
    input wire        phaseVNegativePin,
    input wire        phaseWPositivePin,
    input wire        phaseWNegativePin
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Accepted address phases of the register bus.
    wire       rdTake = hsel && hready && htrans[1] && !hwrite;
    wire       wrTake = hsel && hready && htrans[1] && hwrite;
    wire       quiet;
    reg  [3:0] sinceOut;
    // Counts cycles since a write that may move both pins of a pair at once.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sinceOut <= 4'h0;
        end else if (wrTake && (haddr[7:0] == 8'h38 || haddr[7:0] == 8'h40)) begin
            sinceOut <= 4'h0;
        end else if (sinceOut != 4'hF) begin
            sinceOut <= sinceOut + 4'h1;
        end
    end
    assign quiet = (sinceOut == 4'hF);
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    a_read_wait: assert property (rdTake |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (wrTake |=> hreadyout)
        else $error("write stalled");
    a_stall_cause: assert property (!hreadyout |-> $past(rdTake))
        else $error("stall without a read");
    a_rdata_hold: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
        else $error("hrdata moved outside a read");
    a_gap_u: assert property (quiet && $changed(phaseUPositivePin) |-> $stable(phaseUNegativePin))
        else $error("phase U pins moved together");
    a_gap_v: assert property (quiet && $changed(phaseVPositivePin) |-> $stable(phaseVNegativePin))
        else $error("phase V pins moved together");
    a_gap_w: assert property (quiet && $changed(phaseWPositivePin) |-> $stable(phaseWNegativePin))
        else $error("phase W pins moved together");
    a_sync_once: assert property ($changed(ch3PinA) |=> $stable(ch3PinA))
        else $error("sync pin toggled twice");
    c_read: cover property (rdTake ##2 hreadyout);
    c_pulse: cover property (quiet && $rose(phaseVPositivePin));
    c_sync: cover property ($changed(ch3PinA));
endmodule

bind cpwm_timer cpwm_timer_asserts cpwm_timer_asserts_i (.clk_sys, .rst_n, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .ch3PinA, .phaseUPositivePin,
    .phaseUNegativePin, .phaseVPositivePin, .phaseVNegativePin, .phaseWPositivePin,
    .phaseWNegativePin);

//--- testbench/cpwm_gate_model.sv
`timescale 1ns/10ps
module cpwm_gate_model (
    input  wire clk_sys,
    input  wire watch,
    input  wire phaseUPositivePin,
    input  wire phaseUNegativePin,
    input  wire phaseVPositivePin,
    input  wire phaseVNegativePin,
    input  wire phaseWPositivePin,
    input  wire phaseWNegativePin,
    output int  overlapCount,
    output int  negActive
);
    wire [2:0] posOn = {phaseUPositivePin, phaseVPositivePin, phaseWPositivePin};
    wire [2:0] negOn = {phaseUNegativePin, phaseVNegativePin, phaseWNegativePin};
    // Gates are active high; both switches of one leg on together is a shoot-through.
    always @(posedge clk_sys) begin
        if (watch) begin
            overlapCount <= overlapCount + $countones(posOn & negOn);
            negActive <= negActive + $countones(negOn);
        end
    end
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/10ps
`include "cpwm_defs.vh"
module tb_top;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic        watch = 1'b0;
    logic [31:0] rd;
    logic [31:0] v;
    wire         hready;
    wire         hreadyout;
    wire         hresp;
    wire [31:0]  hrdata;
    wire         ch3PinA, phaseUPositivePin, phaseUNegativePin, phaseVPositivePin;
    wire         phaseVNegativePin, phaseWPositivePin, phaseWNegativePin;
    int          miscompares = 0;
    int          total_checks = 0;
    int          seed = 24234;
    int          len, overlapCount, negActive;
    int          hi[3], base[3], duty[3];
    logic [7:0]  dutyReg[3] = '{`CPWM_OFS_DUTY3, `CPWM_OFS_DUTYA4, `CPWM_OFS_DUTYB4};
    logic [7:0]  dutyBuf[3] = '{`CPWM_OFS_DUTYBUF3, `CPWM_OFS_DUTYBUFA4, `CPWM_OFS_DUTYBUFB4};
    assign hready = hreadyout;
    cpwm_timer cpwm_timer_i (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hresp, .hrdata, .ch3PinA, .phaseUPositivePin, .phaseUNegativePin,
        .phaseVPositivePin, .phaseVNegativePin, .phaseWPositivePin, .phaseWNegativePin);
    cpwm_gate_model cpwm_gate_model_i (.clk_sys, .watch, .phaseUPositivePin, .phaseUNegativePin,
        .phaseVPositivePin, .phaseVNegativePin, .phaseWPositivePin, .phaseWNegativePin,
        .overlapCount, .negActive);
    // Free-running 40 MHz system clock.
    always #12.5 clk_sys = ~clk_sys;
    // One single word transfer; read data is taken at the closing ready edge.
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task checkReg(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task checkNum(input string n, input int e, input int g);
        total_checks++;
        if (g != e) begin
            miscompares++;
            $display("MISMATCH %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task rdChk(input string n, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h00000000);
        checkReg(n, e, rd);
    endtask
    // Runs to the next sync pin toggle, counting clocks and positive-pin high time.
    task waitToggle;
        logic s;
        s = ch3PinA;
        len = 0;
        hi = '{0, 0, 0};
        do begin
            @(negedge clk_sys);
            len++;
            hi[0] += (phaseUPositivePin === 1'b1);
            hi[1] += (phaseVPositivePin === 1'b1);
            hi[2] += (phaseWPositivePin === 1'b1);
        end while (ch3PinA === s && len < 2000);
        if (len >= 2000) miscompares++;
    endtask
    // Clocks in one carrier period for a half period and a tick divider.
    function int periodClocks(input int half, input int div);
        return 2 * half * div;
    endfunction
    task complete_run;
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Cuts a hung run short long after the expected end.
    initial begin
        #(25 * 40000);
        miscompares++;
        complete_run;
    end
    // Main sequence: register file, carrier, buffered duty updates, write lock.
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int a = 4; a <= 8'h34; a += 4) begin
            v = {16'h0000, 16'($random(seed))};
            xfer(1'b1, 8'(a), v);
            rdChk("word register", 8'(a), v);
        end
        xfer(1'b1, `CPWM_OFS_MODE3, 32'h0000007F);
        rdChk("mode register", `CPWM_OFS_MODE3, 32'h0000003F);
        xfer(1'b1, 8'h44, 32'hFFFFFFFF);
        rdChk("unmapped", 8'h44, 32'h00000000);
        xfer(1'b1, `CPWM_OFS_CTRL4, {29'h0, `CPWM_PSC_DIV4});
        rdChk("counter control", `CPWM_OFS_CTRL4, 32'h00000001);
        xfer(1'b1, `CPWM_OFS_DEAD, 32'h00000004);
        xfer(1'b1, `CPWM_OFS_CNT3, 32'h00000004);
        xfer(1'b1, `CPWM_OFS_CNT4, 32'h00000000);
        xfer(1'b1, `CPWM_OFS_HALF, 32'h00000028);
        xfer(1'b1, `CPWM_OFS_HALFBUF, 32'h00000028);
        xfer(1'b1, `CPWM_OFS_PER3, 32'h0000002C);
        xfer(1'b1, `CPWM_OFS_PERBUF3, 32'h0000002C);
        for (int p = 0; p < 3; p++) begin
            duty[p] = 8 + ($random(seed) & 15);
            xfer(1'b1, dutyReg[p], duty[p]);
            xfer(1'b1, dutyBuf[p], duty[p]);
        end
        xfer(1'b1, `CPWM_OFS_OUTCTL, 32'h00000043);
        xfer(1'b1, `CPWM_OFS_MODE3, 32'h0000003F);
        xfer(1'b1, `CPWM_OFS_RUN, 32'h00000001);
        waitToggle;
        watch = 1'b1;
        waitToggle;
        checkNum("carrier period", periodClocks(40, 4), len);
        base = hi;
        for (int p = 0; p < 3; p++) begin
            duty[p] += 5;
            xfer(1'b1, dutyBuf[p], duty[p]);
            waitToggle;
            checkNum("pulse before boundary", base[p], hi[p]);
            waitToggle;
            base[p] -= 40;
            for (int q = 0; q < 3; q++) checkNum("pulse width", base[q], hi[q]);
        end
        xfer(1'b1, `CPWM_OFS_HALFBUF, 32'h00000030);
        xfer(1'b1, `CPWM_OFS_PERBUF3, 32'h00000034);
        waitToggle;
        waitToggle;
        checkNum("new period", periodClocks(48, 4), len);
        xfer(1'b1, `CPWM_OFS_CTRL4, {27'h0, `CPWM_EDGE_FALL, `CPWM_PSC_DIV1});
        waitToggle;
        waitToggle;
        checkNum("falling edge period", periodClocks(48, 1), len);
        watch = 1'b0;
        checkNum("shoot-through cycles", 0, overlapCount);
        checkNum("negative drive seen", 1, int'(negActive > 0));
        xfer(1'b1, `CPWM_OFS_OUTCTL, 32'h00000041);
        rdChk("output control", `CPWM_OFS_OUTCTL, 32'h00000041);
        xfer(1'b1, `CPWM_OFS_OUTCTL, 32'h00000049);
        xfer(1'b1, `CPWM_OFS_OUTCTL, 32'h0000004E);
        rdChk("locked output control", `CPWM_OFS_OUTCTL, 32'h00000049);
        complete_run;
    end
endmodule
